// File: hw/addr_former.sv
// operand address formation: base relocation, single/double indexing, indirect chain
// assumes: indirect words are returned by main storage with ind_valid and bit 31 = further level
`default_nettype none
module addr_former (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // request from sequencer
  input  wire logic        start,
  input  wire logic [23:0] disp,
  input  wire logic [31:0] index1,
  input  wire logic [31:0] index2,
  input  wire logic        use_x1,
  input  wire logic        use_x2,
  input  wire logic [23:0] reloc,
  input  wire logic        indirect,
  // storage path for indirect words
  output logic             ind_req,
  output logic     [23:0]  ind_addr,
  input  wire logic        ind_valid,
  input  wire logic [31:0] ind_word,
  // result
  output logic             done,
  output logic             overflow,
  output logic     [23:0]  addr
);
  regstack_pkg::af_state_t state_ff, nxt_state;
  logic [23:0] addr_ff, nxt_addr;
  logic [3:0]  lvl_ff, nxt_lvl;
  logic [23:0] eff;

  // single or double indexing, then relocation
  assign eff = disp + (use_x1 ? index1[23:0] : 24'h00_0000)
                    + (use_x2 ? index2[23:0] : 24'h00_0000) + reloc;

  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_lvl   = lvl_ff;
    case (state_ff)
      regstack_pkg::AF_IDLE: begin
        if (start) begin
          nxt_addr  = eff;
          nxt_lvl   = 4'h0;
          nxt_state = indirect ? regstack_pkg::AF_IND : regstack_pkg::AF_DONE;
        end
      end
      regstack_pkg::AF_IND: begin
        if (ind_valid) begin
          nxt_addr = ind_word[23:0] + reloc;
          nxt_lvl  = lvl_ff + 4'h1;
          if (!ind_word[31]) begin
            nxt_state = regstack_pkg::AF_DONE;
          end else if (lvl_ff + 4'h1 >= 4'(regstack_pkg::IND_MAX)) begin
            // chain deeper than allowed is stopped rather than looping forever
            nxt_state = regstack_pkg::AF_ERR;
          end
        end
      end
      regstack_pkg::AF_DONE: nxt_state = regstack_pkg::AF_IDLE;
      regstack_pkg::AF_ERR:  nxt_state = regstack_pkg::AF_IDLE;
      default:               nxt_state = regstack_pkg::AF_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= regstack_pkg::AF_IDLE;
      addr_ff  <= regstack_pkg::ADDR_RESET;
      lvl_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      lvl_ff   <= nxt_lvl;
    end
  end

  assign ind_req  = (state_ff == regstack_pkg::AF_IND);
  assign ind_addr = addr_ff;
  assign done     = (state_ff == regstack_pkg::AF_DONE) || (state_ff == regstack_pkg::AF_ERR);
  assign overflow = (state_ff == regstack_pkg::AF_ERR);
  assign addr     = addr_ff;
endmodule : addr_former
`default_nettype wire

// File: hw/dec_format.sv
// decimal packed/unpacked conversion on one 32-bit working word
// assumes: pack takes four zoned bytes (low half) or eight from two words is left to microcode
`default_nettype none
module dec_format (
  // conversion request
  input  wire logic [31:0]              src,
  input  wire regstack_pkg::dec_cmd_t   cmd,
  input  wire logic                     low_sign,
  // result
  output logic     [31:0]               result
);
  logic [15:0] packed_w;
  logic [31:0] zoned_w;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_nib
      // pack: keep digit nibble of each zoned byte
      assign packed_w[i*4 +: 4] = src[i*8 +: 4];
      // unpack: digits sit above the packed sign nibble; each gets a zone above it
      assign zoned_w[i*8 +: 4] = src[i*4+4 +: 4];
      if (i == 0) begin : g_sign
        // lowest byte: the packed sign nibble becomes the zone of that byte
        assign zoned_w[7:4] = low_sign ? src[3:0] : regstack_pkg::ZONE_DIGIT;
      end else begin : g_zone
        assign zoned_w[i*8+4 +: 4] = regstack_pkg::ZONE_DIGIT;
      end
    end
  endgenerate

  always_comb begin
    case (cmd)
      // the zone of the lowest byte is carried to the sign nibble position
      regstack_pkg::DC_PACK:   result = {12'h000, packed_w[15:0], src[7:4]};
      regstack_pkg::DC_UNPACK: result = zoned_w;
      default:                 result = src;
    endcase
  end
endmodule : dec_format
`default_nettype wire

// File: hw/register_stack.sv
// register stack of the arithmetic section: general, floating and working registers
// assumes: sequencer decodes op codes into the select/format controls; one clock domain
`default_nettype none
// Operation
// - fixed-point operands are held and extended as twos complement
// - floating and decimal values keep sign plus magnitude, never complemented
// - two sets of sixteen general registers
// - general registers are 32-bit; bit 31 set means negative
// - half-word loads copy the sign into the upper sixteen bits
// - double words use even-odd register pairs addressed by the even number
// - four 64-bit floating registers, short or long operands
// - short float writes touch only the upper half
// - 4-bit fields select registers; op code picks floating or general file
// - floating registers answer only to numbers 0, 2, 4, 6
// - eight working registers serve decimal arithmetic on variable fields
// - packed decimal: two digits per byte, sign in lowest nibble
// - zoned decimal: zone high nibble, digit low, lowest zone is sign
// - packed to zoned and zoned to packed conversion
// - single and double indexing with relocation form operand addresses
// - indirect addressing stops after eight levels
module register_stack (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // register selection
  input  wire logic                     set_sel,
  input  wire logic                     fp_file,
  input  wire logic [3:0]               rsel_a,
  input  wire logic [3:0]               rsel_b,
  // write port
  input  wire logic                     wr_en,
  input  wire logic [3:0]               wr_sel,
  input  wire regstack_pkg::gr_wfmt_t   wr_fmt,
  input  wire logic                     fp_long,
  input  wire logic [63:0]              wr_data,
  // working registers and decimal conversion
  input  wire logic                     wk_wr_en,
  input  wire logic [2:0]               wk_sel,
  input  wire logic [31:0]              wk_data,
  input  wire regstack_pkg::dec_cmd_t   dec_cmd,
  // address formation
  input  wire logic                     af_start,
  input  wire logic [23:0]              af_disp,
  input  wire logic [3:0]               af_x1,
  input  wire logic [3:0]               af_x2,
  input  wire logic [23:0]              af_reloc,
  input  wire logic                     af_indirect,
  output logic                          ind_req,
  output logic     [23:0]               ind_addr,
  input  wire logic                     ind_valid,
  input  wire logic [31:0]              ind_word,
  output logic                          af_done,
  output logic                          af_overflow,
  output logic     [23:0]               af_addr,
  // read data
  output logic     [63:0]               rd_a,
  output logic     [31:0]               rd_b,
  output logic                          rd_a_neg,
  output logic                          fp_sel_err,
  output logic     [31:0]               wk_rd,
  // alignment check of storage operands
  input  wire logic [23:0]              mem_addr,
  input  wire regstack_pkg::gr_wfmt_t   mem_fmt,
  output logic                          misalign
);
  logic [31:0] gr_ff  [2][16];
  logic [31:0] nxt_gr [2][16];
  logic [63:0] fr_ff  [4];
  logic [63:0] nxt_fr [4];
  logic [31:0] wk_ff  [8];
  logic [31:0] nxt_wk [8];
  logic [63:0] rd_a_ff, nxt_rd_a;
  logic [31:0] rd_b_ff, nxt_rd_b;
  logic        fp_err_ff, nxt_fp_err;
  logic [31:0] wk_rd_ff, nxt_wk_rd;
  logic [31:0] dec_out;
  logic [31:0] wr_word;
  logic [3:0]  pair_lo;
  logic [1:0]  fp_idx;
  logic        fp_legal;

  dec_format u_dec (
    .src      (wk_ff[wk_sel]),
    .cmd      (dec_cmd),
    .low_sign (1'b1),
    .result   (dec_out)
  );

  addr_former u_af (
    .clk       (clk),
    .arst_n    (arst_n),
    .start     (af_start),
    .disp      (af_disp),
    .index1    (gr_ff[set_sel][af_x1]),
    .index2    (gr_ff[set_sel][af_x2]),
    .use_x1    (af_x1 != 4'h0), // register zero means no index
    .use_x2    (af_x2 != 4'h0),
    .reloc     (af_reloc),
    .indirect  (af_indirect),
    .ind_req   (ind_req),
    .ind_addr  (ind_addr),
    .ind_valid (ind_valid),
    .ind_word  (ind_word),
    .done      (af_done),
    .overflow  (af_overflow),
    .addr      (af_addr)
  );

  // half words are sign extended; full words pass unchanged
  assign wr_word = (wr_fmt == regstack_pkg::GW_HALF) ?
                   {{16{wr_data[15]}}, wr_data[15:0]} : wr_data[31:0];
  assign pair_lo = {wr_sel[3:1], 1'b0};
  assign fp_idx  = wr_sel[2:1];
  // odd numbers and numbers above six do not reach the floating file
  assign fp_legal = (wr_sel[0] == 1'b0) && (wr_sel[3] == 1'b0);

  always_comb begin
    nxt_gr = gr_ff;
    if (wr_en && !fp_file) begin
      if (wr_fmt == regstack_pkg::GW_DBL) begin
        // even register gets the high word with the sign, odd gets the low word
        nxt_gr[set_sel][pair_lo]        = wr_data[63:32];
        nxt_gr[set_sel][pair_lo | 4'h1] = wr_data[31:0];
      end else begin
        nxt_gr[set_sel][wr_sel] = wr_word;
      end
    end
  end

  // floating file is written only through its own legal numbers
  always_comb begin
    nxt_fr = fr_ff;
    if (wr_en && fp_file && fp_legal) begin
      if (fp_long) begin
        nxt_fr[fp_idx] = wr_data;
      end else begin
        // short operand lives in the high half; low half kept
        nxt_fr[fp_idx][63:32] = wr_data[63:32];
      end
    end
  end

  always_comb begin
    nxt_wk = wk_ff;
    if (wk_wr_en) begin
      nxt_wk[wk_sel] = wk_data;
    end else if (dec_cmd != regstack_pkg::DC_NONE) begin
      nxt_wk[wk_sel] = dec_out;
    end
  end

  always_comb begin
    nxt_fp_err = 1'b0;
    nxt_wk_rd  = wk_ff[wk_sel];
    nxt_rd_b   = gr_ff[set_sel][rsel_b];
    if (fp_file) begin
      if (rsel_a[0] || rsel_a[3]) begin
        nxt_rd_a   = regstack_pkg::DWORD_RESET;
        nxt_fp_err = 1'b1;
      end else begin
        nxt_rd_a = fr_ff[rsel_a[2:1]];
      end
    end else begin
      // even or odd select reads the whole pair, high word first
      nxt_rd_a = {gr_ff[set_sel][{rsel_a[3:1], 1'b0}],
                  gr_ff[set_sel][{rsel_a[3:1], 1'b1}]};
    end
  end

  // general register sets
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < regstack_pkg::NUM_SETS; s++) begin
        for (int r = 0; r < regstack_pkg::NUM_GR; r++) begin
          gr_ff[s][r] <= regstack_pkg::WORD_RESET;
        end
      end
    end else begin
      gr_ff <= nxt_gr;
    end
  end

  // floating registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int f = 0; f < regstack_pkg::NUM_FR; f++) begin
        fr_ff[f] <= regstack_pkg::DWORD_RESET;
      end
    end else begin
      fr_ff <= nxt_fr;
    end
  end

  // decimal working registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int w = 0; w < regstack_pkg::NUM_WR; w++) begin
        wk_ff[w] <= regstack_pkg::WORD_RESET;
      end
    end else begin
      wk_ff <= nxt_wk;
    end
  end

  // registered read ports
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_a_ff   <= regstack_pkg::DWORD_RESET;
      rd_b_ff   <= regstack_pkg::WORD_RESET;
      fp_err_ff <= 1'b0;
      wk_rd_ff  <= regstack_pkg::WORD_RESET;
    end else begin
      rd_a_ff   <= nxt_rd_a;
      rd_b_ff   <= nxt_rd_b;
      fp_err_ff <= nxt_fp_err;
      wk_rd_ff  <= nxt_wk_rd;
    end
  end

  assign rd_a       = rd_a_ff;
  assign rd_b       = rd_b_ff;
  // sign of the pair's high (even) word, or of the floating register
  assign rd_a_neg   = rd_a_ff[63];
  assign fp_sel_err = fp_err_ff;
  assign wk_rd      = wk_rd_ff;

  // flags operands that storage should have placed on their own boundary
  always_comb begin
    case (mem_fmt)
      regstack_pkg::GW_HALF: misalign = mem_addr[0];
      regstack_pkg::GW_FULL: misalign = |mem_addr[1:0];
      regstack_pkg::GW_DBL:  misalign = |mem_addr[2:0];
      default:               misalign = 1'b0;
    endcase
  end
endmodule : register_stack
`default_nettype wire

// File: hw/regstack_pkg.sv
// package: constants shared by the register stack, decimal format unit and address former
// assumes: one processor clock; the sequencer drives all command ports synchronously
`default_nettype none
package regstack_pkg;
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned DWORD_W      = 64;
  localparam int unsigned HALF_W       = 16;
  localparam int unsigned SEL_W        = 4;
  localparam int unsigned NUM_GR       = 16;
  localparam int unsigned NUM_SETS     = 2;
  localparam int unsigned NUM_FR       = 4;
  localparam int unsigned NUM_WR       = 8;
  localparam int unsigned WR_SEL_W     = 3;
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned IND_MAX      = 8;
  localparam int unsigned IND_CNT_W    = 4;
  localparam int unsigned SIGN_BIT     = 31;
  localparam int unsigned NIB_W        = 4;
  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
  localparam logic [63:0] DWORD_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [3:0]  ZONE_DIGIT   = 4'hf;
  localparam logic [23:0] ADDR_RESET   = 24'h00_0000;

  // operand format selected by the sequencer for a general register write
  typedef enum logic [1:0] {
    GW_FULL = 2'h0,
    GW_HALF = 2'h1,
    GW_DBL  = 2'h2
  } gr_wfmt_t;

  // decimal conversion command
  typedef enum logic [1:0] {
    DC_NONE   = 2'h0,
    DC_PACK   = 2'h1,
    DC_UNPACK = 2'h2
  } dec_cmd_t;

  // address former states, one-hot
  typedef enum logic [3:0] {
    AF_IDLE = 4'h1,
    AF_IND  = 4'h2,
    AF_DONE = 4'h4,
    AF_ERR  = 4'h8
  } af_state_t;
endpackage : regstack_pkg
`default_nettype wire

// File: test/ind_storage.sv
// partner: main storage returning indirect address words on request
// assumes: bench sets dly and chain and pulses clr with each address request
`default_nettype none
module ind_storage (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // bench control
  input  wire logic        clr,
  input  wire logic [3:0]  dly,
  input  wire logic [3:0]  chain,
  // storage path
  input  wire logic        ind_req,
  input  wire logic [23:0] ind_addr,
  output logic             ind_valid,
  output logic [31:0]      ind_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [3:0] lvl;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_valid <= 1'b0;
      ind_word <= 32'h0000_0000;
      cnt <= 4'h0;
      lvl <= 4'h0;
    end else begin
      ind_valid <= 1'b0;
      // idle bus must not echo the last word
      ind_word <= ~ind_word;
      if (clr) lvl <= 4'h0;
      // skip the request seen with our own answer: it is stale
      if (ind_valid || !ind_req) cnt <= 4'h0;
      else if (cnt < dly) cnt <= cnt + 4'h1;
      else begin
        ind_valid <= 1'b1;
        ind_word <= {lvl < chain, 7'h00, ind_addr + 24'h00_0010};
        lvl <= lvl + 4'h1;
      end
    end
  end
endmodule : ind_storage
`default_nettype wire

// File: test/register_stack_props.sv
// checker: port relations of the register stack
// assumes: bound into register_stack; one clock, arst_n active low
`default_nettype none
module register_stack_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register reads
  input wire logic fp_file,
  input wire logic [3:0] rsel_a,
  input wire logic [63:0] rd_a,
  input wire logic rd_a_neg,
  input wire logic fp_sel_err,
  // address formation
  input wire logic af_start,
  input wire logic af_indirect,
  input wire logic [23:0] af_disp,
  input wire logic [23:0] af_reloc,
  input wire logic [3:0] af_x1,
  input wire logic [3:0] af_x2,
  input wire logic ind_req,
  input wire logic [23:0] ind_addr,
  input wire logic ind_valid,
  input wire logic [31:0] ind_word,
  input wire logic af_done,
  input wire logic af_overflow,
  input wire logic [23:0] af_addr,
  // alignment
  input wire logic [23:0] mem_addr,
  input wire regstack_pkg::gr_wfmt_t mem_fmt,
  input wire logic misalign
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_ff;
  logic nxt_busy;
  logic [3:0] lvl_ff;
  logic [3:0] nxt_lvl;
  logic go;
  assign go = af_start && !busy_ff;
  always_comb begin
    nxt_busy = af_done ? 1'b0 : busy_ff | af_start;
    nxt_lvl = go ? 4'h0 : lvl_ff + 4'(ind_valid & ind_req);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      lvl_ff <= 4'h0;
    end else begin
      busy_ff <= nxt_busy;
      lvl_ff <= nxt_lvl;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_FP_BAD: assert property (fp_file && (rsel_a[0] || rsel_a[3]) |=> fp_sel_err)
    else $error("bad fp select not flagged");
  AST_FP_OK: assert property (fp_file && !rsel_a[0] && !rsel_a[3] |=> !fp_sel_err)
    else $error("good fp select flagged");
  AST_NEG: assert property (rd_a_neg == rd_a[63])
    else $error("sign flag differs");
  AST_DIRECT: assert property (go && !af_indirect |=> af_done && !af_overflow)
    else $error("direct address late");
  AST_IND_REQ: assert property (go && af_indirect |=> ind_req && !af_done)
    else $error("no indirect request");
  AST_IND_ADDR: assert property (go && af_indirect && af_x1 == 4'h0 && af_x2 == 4'h0 |=>
      ind_addr == $past(af_disp) + $past(af_reloc)) else $error("indirect address wrong");
  AST_IND_END: assert property (ind_valid && ind_req && !ind_word[31] |=>
      af_done && af_addr == $past(ind_word[23:0]) + $past(af_reloc)) else $error("chain end");
  AST_OVF: assert property (af_overflow |-> af_done && lvl_ff == 4'h8)
    else $error("overflow count wrong");
  AST_HALF_AL: assert property (mem_fmt == regstack_pkg::GW_HALF |->
      misalign == mem_addr[0]) else $error("half alignment wrong");
  AST_DBL_AL: assert property (mem_fmt == regstack_pkg::GW_DBL |->
      misalign == |mem_addr[2:0]) else $error("double alignment wrong");
  AST_FULL_AL: assert property (mem_fmt == regstack_pkg::GW_FULL |->
      misalign == |mem_addr[1:0]) else $error("full alignment wrong");
  AST_FP_ZERO: assert property (fp_file && (rsel_a[0] || rsel_a[3]) |=>
      rd_a == 64'h0000_0000_0000_0000 && !rd_a_neg) else $error("bad fp read not zero");
endmodule : register_stack_props
bind register_stack register_stack_props chk (.*);
`default_nettype wire

// File: test/register_stack_tb.sv
// testbench: register stack against a model of registers, decimal and addressing
// assumes: ind_storage stands in for main storage; checker bound separately
`default_nettype none
module register_stack_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, set_sel = 0, fp_file = 0, wr_en = 0, fp_long = 0;
  logic wk_wr_en = 0, af_start = 0, af_indirect = 0, clr = 0;
  logic [3:0] rsel_a = 0, rsel_b = 0, wr_sel = 0, af_x1 = 0, af_x2 = 0, dly = 0, chain = 0;
  logic [2:0] wk_sel = 0;
  logic [63:0] wr_data = 0, rd_a;
  logic [31:0] wk_data = 0, rd_b, wk_rd, ind_word, w;
  logic [23:0] af_disp = 0, af_reloc = 0, mem_addr = 0, ind_addr, af_addr;
  logic ind_req, ind_valid, af_done, af_overflow, rd_a_neg, fp_sel_err, misalign;
  regstack_pkg::gr_wfmt_t wr_fmt = regstack_pkg::GW_FULL, mem_fmt = regstack_pkg::GW_FULL;
  regstack_pkg::dec_cmd_t dec_cmd = regstack_pkg::DC_NONE;
  logic [31:0] gr [2][16] = '{default: '0};
  logic [63:0] fr [4] = '{default: '0};
  logic [3:0] r;
  int failures = 0, checked = 0;
  register_stack dut (.*);
  ind_storage mem (.*);
  always #20 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // wr_en is left high so writes may run back to back; rd lowers it
  task automatic gwr(input logic fp, input logic [3:0] s, input int f, input logic lg);
    wr_data = {$urandom, $urandom};
    fp_file = fp;
    wr_sel = s;
    wr_fmt = regstack_pkg::gr_wfmt_t'(f);
    fp_long = lg;
    wr_en = 1'b1;
    if (fp && !s[0] && !s[3]) fr[s[2:1]] = lg ? wr_data : {wr_data[63:32], fr[s[2:1]][31:0]};
    else if (!fp && f == 1) gr[set_sel][s] = {{16{wr_data[15]}}, wr_data[15:0]};
    else if (!fp && f == 2) begin
      gr[set_sel][s] = wr_data[63:32];
      gr[set_sel][s | 4'h1] = wr_data[31:0];
    end else if (!fp) gr[set_sel][s] = wr_data[31:0];
    @(negedge clk);
  endtask : gwr
  task automatic rd(input logic fp, input logic [3:0] a);
    wr_en = 1'b0;
    fp_file = fp;
    rsel_a = a;
    rsel_b = a;
    @(negedge clk);
  endtask : rd
  task automatic af(input logic ind, input logic [3:0] x1, input logic [3:0] x2, input int ch);
    logic [23:0] a;
    clr = 1'b1;
    chain = 4'(ch);
    dly = 4'($urandom % 4);
    af_disp = 24'($urandom);
    af_reloc = 24'($urandom);
    af_x1 = x1;
    af_x2 = x2;
    af_indirect = ind;
    af_start = 1'b1;
    a = af_disp + af_reloc + (x1 != 0 ? gr[set_sel][x1][23:0] : 24'h00_0000)
        + (x2 != 0 ? gr[set_sel][x2][23:0] : 24'h00_0000);
    @(negedge clk);
    af_start = 1'b0;
    clr = 1'b0;
    for (int n = 0; n < 300 && af_done !== 1'b1; n++) @(negedge clk);
    for (int k = 0; ind && k <= ch && k < 8; k++) a = a + 24'h00_0010 + af_reloc;
    chk(af_done, 1'b1);
    chk(af_overflow, ch > 7);
    if (ch < 8) chk(af_addr, a);
    @(negedge clk);
  endtask : af
  initial begin
    void'($urandom(32));
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      set_sel = 1'($urandom);
      r = 4'($urandom) & (i % 3 == 2 ? 4'he : 4'hf);
      gwr(1'b0, r, i % 3, 1'b0);
      rd(1'b0, r);
      chk(rd_b, gr[set_sel][r]);
      chk(rd_a, {gr[set_sel][r & 4'he], gr[set_sel][r | 4'h1]});
      chk(rd_a_neg, gr[set_sel][r & 4'he][31]);
      set_sel = ~set_sel;
      rd(1'b0, r);
      chk(rd_b, gr[set_sel][r]);
    end
    for (int i = 0; i < 32; i++) gwr(1'b1, 4'(i), 0, i < 16);
    for (int i = 0; i < 16; i++) begin
      rd(1'b1, 4'(i));
      chk(fp_sel_err, i % 2 == 1 || i > 7);
      chk(rd_a, i % 2 == 0 && i < 8 ? fr[i / 2] : 64'h0);
    end
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      wk_sel = 3'(i);
      wk_data = w;
      wk_wr_en = 1'b1;
      @(negedge clk);
      wk_wr_en = 1'b0;
      dec_cmd = i % 2 ? regstack_pkg::DC_UNPACK : regstack_pkg::DC_PACK;
      @(negedge clk);
      dec_cmd = regstack_pkg::DC_NONE;
      @(negedge clk);
      if (i % 2) chk(wk_rd, {4'hf, w[19:16], 4'hf, w[15:12], 4'hf, w[11:8], w[3:0], w[7:4]});
      else chk(wk_rd, {12'h000, w[27:24], w[19:16], w[11:8], w[3:0], w[7:4]});
    end
    for (int i = 0; i < 6; i++) af(1'b0, 4'($urandom), 4'($urandom), 0);
    for (int i = 0; i < 4; i++) af(1'b1, 4'h0, 4'h0, i * 3 - i / 3);
    for (int i = 0; i < 24; i++) begin
      mem_addr = 24'($urandom);
      mem_fmt = regstack_pkg::gr_wfmt_t'(i % 3);
      @(negedge clk);
      chk(misalign, i % 3 == 1 ? mem_addr[0] : i % 3 == 2 ? |mem_addr[2:0] : |mem_addr[1:0]);
    end
    end_sim();
  end
  initial begin
    #400_000;
    failures++;
    end_sim();
  end
endmodule : register_stack_tb
`default_nettype wire
